// [verilog/fsc_device.sv]
// fsc_device: flash end for security register read, deep sleep, wake,
// legacy signature and maker/device identity commands
// assumes link pins synchronous to core_clk, sclk half period of 3+ clocks
// Overview of operation
// - secreg read: opcode, address, dummy, then data
// - sample on sclk rise, drive on fall
// - byte offset increments, wraps from 1FF to 0
// - address selects register one to three, offset
// - deep sleep ignores all but wake, signature
// - sleep opcode alone; entry after timed delay
// - wake only if select rises right after the opcode or once a signature byte has completed
// - reset always returns to standby
// - wake leaves deep sleep at once, standby after wake delay
// - signature repeats until select rises
// - wake, signature refused while write busy
// - identity: opcode, two dummies, address, data
// - address zero maker first, one device first
// - identity codes alternate until select rises
// - dual identity moves two bits per clock after the opcode, which goes one bit per clock
`include "fsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fsc_device #(
    parameter logic [7:0] MAKER_ID = `FSC_MAKER_ID,
    parameter logic [7:0] DEVICE_ID = `FSC_DEVICE_ID,
    parameter logic [7:0] SIGNATURE = `FSC_SIGNATURE,
    parameter int SLEEP_CYC = `FSC_SLEEP_CYC,
    parameter int WAKE_CYC = `FSC_WAKE_CYC,
    parameter int TW = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    fsc_link_if.dev link,
    input wire logic wip,
    input wire logic mem_wr_en,
    input wire logic [10:0] mem_wr_idx,
    input wire logic [7:0] mem_wr_data,
    output logic deep_sleep,
    output logic standby
);
    logic [7:0] mem [0:`FSC_SECREG_DEPTH-1];
    logic sclk_q_ff;
    logic cs_q_ff;
    fsc_pkg::fsc_phase_t phase_ff;
    fsc_pkg::fsc_power_t power_ff;
    logic [4:0] bcnt_ff;
    logic [7:0] opc_ff;
    logic [23:0] sh_ff;
    logic exact_ff;
    logic cmd_ok_ff;
    logic rd_once_ff;
    logic dual_ff;
    logic [1:0] sel_ff;
    logic sel_ok_ff;
    logic [8:0] off_ff;
    logic swap_ff;
    logic drive_ff;
    logic [7:0] out_sh_ff;
    logic io0_ff;
    logic io1_ff;
    logic sleep_go;
    logic wake_go;
    logic sleep_done;
    logic wake_done;
    logic [7:0] cur_byte;

    wire rise = !link.cs_n && link.sclk && !sclk_q_ff;
    wire fall = !link.cs_n && !link.sclk && sclk_q_ff;
    wire cs_end = link.cs_n && !cs_q_ff;
    wire two = dual_ff && (phase_ff == fsc_pkg::PH_ADDR || phase_ff == fsc_pkg::PH_OUT);
    wire [4:0] cnt_nxt = bcnt_ff + (two ? 5'h02 : 5'h01);
    wire [23:0] sh_nxt = two ? {sh_ff[21:0], link.io_line1, link.io_line0}
                             : {sh_ff[22:0], link.io_line0};
    wire asleep = (power_ff != fsc_pkg::PW_STANDBY);

    // decides whether a freshly received opcode is taken at all
    function automatic logic accept(input logic [7:0] op, input logic slp, input logic busy);
        unique case (op)
            `FSC_OP_WAKE: accept = !busy;
            `FSC_OP_SECREG, `FSC_OP_ID, `FSC_OP_ID2, `FSC_OP_SLEEP: accept = !slp;
            default: accept = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sclk_q_ff <= 1'b0;
            cs_q_ff <= 1'b1;
        end
        else
        begin
            sclk_q_ff <= link.sclk;
            cs_q_ff <= link.cs_n;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (mem_wr_en && (mem_wr_idx < 11'(`FSC_SECREG_DEPTH)))
            mem[mem_wr_idx] <= mem_wr_data;
    end

    ////////////////////////////////////////////////////////////////////////////
    // input side: everything sampled on sclk rise
    always_ff @(posedge core_clk)
    begin
        if (rst || link.cs_n)
        begin
            phase_ff <= fsc_pkg::PH_OPC;
            bcnt_ff <= '0;
            opc_ff <= '0;
            sh_ff <= '0;
            exact_ff <= 1'b0;
            cmd_ok_ff <= 1'b0;
            rd_once_ff <= 1'b0;
            dual_ff <= 1'b0;
        end
        else if (rise)
        begin
            sh_ff <= sh_nxt;
            bcnt_ff <= cnt_nxt;
            exact_ff <= 1'b0;
            unique case (phase_ff)
                fsc_pkg::PH_OPC:
                begin
                    if (cnt_nxt == 5'(`FSC_OPC_RISES))
                    begin
                        opc_ff <= sh_nxt[7:0];
                        bcnt_ff <= '0;
                        exact_ff <= 1'b1;
                        cmd_ok_ff <= accept(sh_nxt[7:0], asleep, wip);
                        dual_ff <= (sh_nxt[7:0] == `FSC_OP_ID2);
                        if (accept(sh_nxt[7:0], asleep, wip) && sh_nxt[7:0] != `FSC_OP_SLEEP)
                            phase_ff <= fsc_pkg::PH_ADDR;
                        else
                            phase_ff <= fsc_pkg::PH_SKIP;
                    end
                end
                fsc_pkg::PH_ADDR:
                begin
                    if (cnt_nxt == 5'(`FSC_ADDR_RISES))
                    begin
                        bcnt_ff <= '0;
                        phase_ff <= (opc_ff == `FSC_OP_SECREG) ? fsc_pkg::PH_DUMMY : fsc_pkg::PH_OUT;
                    end
                end
                fsc_pkg::PH_DUMMY:
                begin
                    if (cnt_nxt == 5'(`FSC_DUMMY_RISES))
                    begin
                        bcnt_ff <= '0;
                        phase_ff <= fsc_pkg::PH_OUT;
                    end
                end
                fsc_pkg::PH_OUT:
                begin
                    if (cnt_nxt == 5'h08)
                    begin
                        bcnt_ff <= '0;
                        rd_once_ff <= 1'b1;
                    end
                end
                fsc_pkg::PH_SKIP: bcnt_ff <= '0;
            endcase
        end
    end

    // address fields are caught on the last address rise
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sel_ff <= '0;
            sel_ok_ff <= 1'b0;
            off_ff <= '0;
            swap_ff <= 1'b0;
        end
        else if (rise && phase_ff == fsc_pkg::PH_ADDR && cnt_nxt == 5'(`FSC_ADDR_RISES))
        begin
            sel_ff <= sh_nxt[`FSC_SEL_LSB+1:`FSC_SEL_LSB];
            sel_ok_ff <= (sh_nxt[23:14] == 10'h000) && (sh_nxt[11:9] == 3'h0)
                         && (sh_nxt[13:12] != 2'h0);
            off_ff <= sh_nxt[8:0];
            swap_ff <= sh_nxt[0];
        end
        else if (fall && phase_ff == fsc_pkg::PH_OUT && bcnt_ff == 5'h00)
        begin
            off_ff <= off_ff + 9'h001;
            swap_ff <= !swap_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output side: a new byte starts on the first fall of each byte slot
    always_comb
    begin
        unique case (opc_ff)
            `FSC_OP_SECREG: cur_byte = sel_ok_ff ? mem[{sel_ff - 2'h1, off_ff}] : `FSC_BAD_BYTE;
            `FSC_OP_WAKE: cur_byte = SIGNATURE;
            default: cur_byte = swap_ff ? DEVICE_ID : MAKER_ID;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst || link.cs_n)
        begin
            drive_ff <= 1'b0;
            out_sh_ff <= '0;
            io0_ff <= 1'b0;
            io1_ff <= 1'b0;
        end
        else if (fall && phase_ff == fsc_pkg::PH_OUT)
        begin
            drive_ff <= 1'b1;
            if (bcnt_ff == 5'h00)
            begin
                io1_ff <= cur_byte[7];
                io0_ff <= cur_byte[6];
                out_sh_ff <= dual_ff ? {cur_byte[5:0], 2'h0} : {cur_byte[6:0], 1'b0};
            end
            else
            begin
                io1_ff <= out_sh_ff[7];
                io0_ff <= out_sh_ff[6];
                out_sh_ff <= dual_ff ? {out_sh_ff[5:0], 2'h0} : {out_sh_ff[6:0], 1'b0};
            end
        end
    end

    assign link.d_io1_o = io1_ff;
    assign link.d_io0_o = io0_ff;
    assign link.d_io1_oe = drive_ff;
    assign link.d_io0_oe = drive_ff && dual_ff;

    ////////////////////////////////////////////////////////////////////////////
    // power state; a late wake may still cancel a pending entry
    assign sleep_go = cs_end && cmd_ok_ff && exact_ff && opc_ff == `FSC_OP_SLEEP;
    assign wake_go = cs_end && cmd_ok_ff && !wip && opc_ff == `FSC_OP_WAKE
                     && (exact_ff || (phase_ff == fsc_pkg::PH_OUT && rd_once_ff));

    always_ff @(posedge core_clk)
    begin
        if (rst)
            power_ff <= fsc_pkg::PW_STANDBY;
        else
        begin
            unique case (power_ff)
                fsc_pkg::PW_STANDBY:
                    if (sleep_go)
                        power_ff <= fsc_pkg::PW_ENTER;
                fsc_pkg::PW_ENTER:
                    if (wake_go)
                        power_ff <= fsc_pkg::PW_STANDBY;
                    else if (sleep_done)
                        power_ff <= fsc_pkg::PW_DEEP;
                fsc_pkg::PW_DEEP:
                    if (wake_go)
                        power_ff <= fsc_pkg::PW_WAKE;
                fsc_pkg::PW_WAKE:
                    if (wake_done)
                        power_ff <= fsc_pkg::PW_STANDBY;
            endcase
        end
    end

    fsc_timer #(.W(TW)) u_sleep_tmr (
        .core_clk(core_clk),
        .rst(rst),
        .start(sleep_go && power_ff == fsc_pkg::PW_STANDBY),
        .cancel(wake_go),
        .cycles(TW'(SLEEP_CYC)),
        .busy(),
        .done(sleep_done)
    );

    fsc_timer #(.W(TW)) u_wake_tmr (
        .core_clk(core_clk),
        .rst(rst),
        .start(wake_go && power_ff == fsc_pkg::PW_DEEP),
        .cancel(1'b0),
        .cycles(TW'(WAKE_CYC)),
        .busy(),
        .done(wake_done)
    );

    assign deep_sleep = (power_ff == fsc_pkg::PW_DEEP);
    assign standby = (power_ff == fsc_pkg::PW_STANDBY);
endmodule // fsc_device
`default_nettype wire

// [verilog/fsc_params.svh]
// fsc_params.svh: opcodes, address fields and timing counts of the flash command block
// assumes core_clk at 100 MHz; included by its bare name
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH
`define FSC_CLK_NS 10
`define FSC_OP_SECREG 8'h48
`define FSC_OP_SLEEP 8'hB9
`define FSC_OP_WAKE 8'hAB
`define FSC_OP_ID 8'h90
`define FSC_OP_ID2 8'h92
`define FSC_ADDR_RISES 24
`define FSC_DUMMY_RISES 8
`define FSC_OPC_RISES 8
`define FSC_SEL_LSB 12
`define FSC_SECREG_DEPTH 1536
`define FSC_BAD_BYTE 8'hFF
// arbitrary identity values
`define FSC_MAKER_ID 8'h5A
`define FSC_DEVICE_ID 8'h3C
`define FSC_SIGNATURE 8'hC3
`define FSC_SLEEP_NS 3000
`define FSC_WAKE_NS 8000
// least times round up to whole cycles
`define FSC_SLEEP_CYC ((`FSC_SLEEP_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_WAKE_CYC ((`FSC_WAKE_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_SCLK_HALF 4
`define FSC_MIN_GAP 2
`endif

// [verilog/fsc_pkg.sv]
// fsc_pkg: state and command types shared by both ends
// assumes nothing of its surroundings
`default_nettype none
package fsc_pkg;
    typedef enum logic [4:0] {PH_OPC = 5'h01, PH_ADDR = 5'h02, PH_DUMMY = 5'h04,
        PH_OUT = 5'h08, PH_SKIP = 5'h10} fsc_phase_t;
    typedef enum logic [3:0] {PW_STANDBY = 4'h1, PW_ENTER = 4'h2, PW_DEEP = 4'h4,
        PW_WAKE = 4'h8} fsc_power_t;
    typedef enum logic [2:0] {HS_IDLE = 3'h1, HS_SHIFT = 3'h2, HS_GAP = 3'h4} fsc_hstate_t;
    typedef enum logic [2:0] {HC_SECREG = 3'h0, HC_SLEEP = 3'h1, HC_WAKE = 3'h2,
        HC_SIG = 3'h3, HC_ID = 3'h4, HC_ID2 = 3'h5} fsc_hcmd_t;
endpackage
`default_nettype wire

// [verilog/fsc_link_if.sv]
// fsc_link_if: serial link between host controller and flash command end
// assumes both ends run on the same core_clk; undriven lines read high
`timescale 1ns/1ps
`default_nettype none
interface fsc_link_if;
    logic cs_n;
    logic sclk;
    logic h_io0_o;
    logic h_io0_oe;
    logic h_io1_o;
    logic h_io1_oe;
    logic d_io0_o;
    logic d_io0_oe;
    logic d_io1_o;
    logic d_io1_oe;
    logic io_line0;
    logic io_line1;
    assign io_line0 = h_io0_oe ? h_io0_o : (d_io0_oe ? d_io0_o : 1'b1);
    assign io_line1 = h_io1_oe ? h_io1_o : (d_io1_oe ? d_io1_o : 1'b1);
    modport dev (input cs_n, sclk, io_line0, io_line1,
        output d_io0_o, d_io0_oe, d_io1_o, d_io1_oe);
    modport host (output cs_n, sclk, h_io0_o, h_io0_oe, h_io1_o, h_io1_oe,
        input io_line0, io_line1);
endinterface
`default_nettype wire

// [verilog/fsc_timer.sv]
// fsc_timer: one-shot delay counter, done pulses in the last busy cycle
// assumes start and cancel are one-cycle pulses on core_clk
`timescale 1ns/1ps
`default_nettype none
module fsc_timer #(
    parameter int W = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic cancel,
    input wire logic [W-1:0] cycles,
    output logic busy,
    output logic done
);
    logic [W-1:0] cnt_ff;
    logic busy_ff;

    always_ff @(posedge core_clk)
    begin
        if (rst || cancel)
        begin
            busy_ff <= 1'b0;
            cnt_ff <= '0;
        end
        else if (start)
        begin
            busy_ff <= 1'b1;
            cnt_ff <= cycles;
        end
        else if (busy_ff)
        begin
            busy_ff <= (cnt_ff > W'(1));
            cnt_ff <= cnt_ff - W'(1);
        end
    end

    assign busy = busy_ff;
    assign done = busy_ff && (cnt_ff == W'(1));
endmodule // fsc_timer
`default_nettype wire

// [verilog/fsc_host.sv]
// fsc_host: host controller issuing the six command forms over the link
// assumes the device end shares core_clk; one command at a time
`include "fsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fsc_host #(
    parameter int SCLK_HALF = `FSC_SCLK_HALF,
    parameter int WAKE_CYC = `FSC_WAKE_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    fsc_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire fsc_pkg::fsc_hcmd_t cmd_op,
    input wire logic [1:0] cmd_sel,
    input wire logic [8:0] cmd_offset,
    input wire logic [7:0] cmd_len,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic done
);
    fsc_pkg::fsc_hstate_t st_ff;
    logic cs_n_ff;
    logic sclk_ff;
    logic [39:0] tx_ff;
    logic [11:0] rises_ff;
    logic [11:0] tx_rises_ff;
    logic [11:0] all_rises_ff;
    logic dual_ff;
    logic [7:0] rx_ff;
    logic [2:0] rx_cnt_ff;
    logic rsp_valid_ff;
    logic [7:0] rsp_data_ff;
    logic [15:0] gap_ff;
    logic [15:0] div_ff;
    logic done_ff;

    wire tick = (st_ff == fsc_pkg::HS_SHIFT) && (div_ff == 16'(SCLK_HALF - 1));
    wire dual_now = dual_ff && (rises_ff >= 12'(`FSC_OPC_RISES));
    wire [7:0] len = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
    wire [23:0] id_addr = {23'h00_0000, cmd_offset[0]};
    wire [2:0] rx_nxt = rx_cnt_ff + (dual_ff ? 3'h2 : 3'h1);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk)
    begin
        if (rst || tick || st_ff != fsc_pkg::HS_SHIFT)
            div_ff <= '0;
        else
            div_ff <= div_ff + 16'h0001;
    end

    always_ff @(posedge core_clk)
    begin
        rsp_valid_ff <= 1'b0;
        done_ff <= 1'b0;
        if (rst)
        begin
            st_ff <= fsc_pkg::HS_IDLE;
            cs_n_ff <= 1'b1;
            sclk_ff <= 1'b0;
            tx_ff <= '0;
            rises_ff <= '0;
            tx_rises_ff <= '0;
            all_rises_ff <= '0;
            dual_ff <= 1'b0;
            rx_ff <= '0;
            rx_cnt_ff <= '0;
            rsp_data_ff <= '0;
            gap_ff <= '0;
        end
        else
        begin
            unique case (st_ff)
                fsc_pkg::HS_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        st_ff <= fsc_pkg::HS_SHIFT;
                        cs_n_ff <= 1'b0;
                        rises_ff <= '0;
                        rx_cnt_ff <= '0;
                        dual_ff <= (cmd_op == fsc_pkg::HC_ID2);
                        gap_ff <= 16'(`FSC_MIN_GAP);
                        unique case (cmd_op)
                            fsc_pkg::HC_SECREG:
                            begin
                                tx_ff <= {`FSC_OP_SECREG, 10'h000, cmd_sel, 3'h0, cmd_offset, 8'h00};
                                tx_rises_ff <= 12'h028;
                                all_rises_ff <= 12'h028 + {1'b0, len, 3'h0};
                            end
                            fsc_pkg::HC_SLEEP, fsc_pkg::HC_WAKE:
                            begin
                                tx_ff <= {(cmd_op == fsc_pkg::HC_WAKE) ? `FSC_OP_WAKE : `FSC_OP_SLEEP, 32'h0000_0000};
                                tx_rises_ff <= 12'h008;
                                all_rises_ff <= 12'h008;
                                if (cmd_op == fsc_pkg::HC_WAKE)
                                    gap_ff <= 16'(WAKE_CYC);
                            end
                            fsc_pkg::HC_SIG:
                            begin
                                tx_ff <= {`FSC_OP_WAKE, 32'h0000_0000};
                                tx_rises_ff <= 12'h020;
                                all_rises_ff <= 12'h020 + {1'b0, len, 3'h0};
                                gap_ff <= 16'(WAKE_CYC);
                            end
                            fsc_pkg::HC_ID:
                            begin
                                tx_ff <= {`FSC_OP_ID, id_addr, 8'h00};
                                tx_rises_ff <= 12'h020;
                                all_rises_ff <= 12'h020 + {1'b0, len, 3'h0};
                            end
                            fsc_pkg::HC_ID2:
                            begin
                                tx_ff <= {`FSC_OP_ID2, id_addr, 8'h00};
                                tx_rises_ff <= 12'h014;
                                all_rises_ff <= 12'h014 + {2'h0, len, 2'h0};
                            end
                            default:
                            begin
                                tx_ff <= '0;
                                tx_rises_ff <= 12'h008;
                                all_rises_ff <= 12'h008;
                            end
                        endcase
                    end
                end
                fsc_pkg::HS_SHIFT:
                begin
                    if (tick && !sclk_ff)
                    begin
                        sclk_ff <= 1'b1;
                        rises_ff <= rises_ff + 12'h001;
                        if (rises_ff >= tx_rises_ff)
                        begin
                            rx_ff <= dual_ff ? {rx_ff[5:0], link.io_line1, link.io_line0}
                                             : {rx_ff[6:0], link.io_line1};
                            rx_cnt_ff <= rx_nxt;
                            if (rx_nxt == 3'h0)
                            begin
                                rsp_valid_ff <= 1'b1;
                                rsp_data_ff <= dual_ff ? {rx_ff[5:0], link.io_line1, link.io_line0}
                                                       : {rx_ff[6:0], link.io_line1};
                            end
                        end
                    end
                    else if (tick)
                    begin
                        sclk_ff <= 1'b0;
                        // select rises right after the final rise, on the byte boundary
                        if (rises_ff == all_rises_ff)
                        begin
                            cs_n_ff <= 1'b1;
                            st_ff <= fsc_pkg::HS_GAP;
                        end
                        else if (rises_ff < tx_rises_ff)
                            tx_ff <= (dual_ff && rises_ff > 12'h008) ? {tx_ff[37:0], 2'h0} : {tx_ff[38:0], 1'b0};
                    end
                end
                fsc_pkg::HS_GAP:
                begin
                    gap_ff <= gap_ff - 16'h0001;
                    if (gap_ff <= 16'h0001)
                    begin
                        st_ff <= fsc_pkg::HS_IDLE;
                        done_ff <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign cmd_ready = (st_ff == fsc_pkg::HS_IDLE);
    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rsp_data_ff;
    assign done = done_ff;
    assign link.cs_n = cs_n_ff;
    assign link.sclk = sclk_ff;
    assign link.h_io1_o = tx_ff[39];
    assign link.h_io0_o = dual_now ? tx_ff[38] : tx_ff[39];
    // hold the lines until the fall after the last rise: the device samples a cycle after sclk goes high
    wire tx_on = !cs_n_ff && ((rises_ff < tx_rises_ff) || (rises_ff == tx_rises_ff && sclk_ff));
    assign link.h_io0_oe = tx_on;
    assign link.h_io1_oe = tx_on && dual_now;
endmodule // fsc_host
`default_nettype wire

// [verification/fsc_link_properties.sv]
// fsc_link_properties: checks on the host/device link
// assumes one core_clk, rst synchronous active high
`timescale 1ns/1ps
`default_nettype none
module fsc_link_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic d_io0_oe,
    input wire logic d_io1_oe,
    input wire logic d_io1_o,
    input wire logic deep_sleep,
    input wire logic standby
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////
a_oe_deselect: assert property (cs_n && $past(cs_n) |-> !d_io0_oe && !d_io1_oe)
    else $error("device drives while deselected");
a_oe_start_sel: assert property ($rose(d_io1_oe) |-> !cs_n && !$past(cs_n))
    else $error("output enabled outside a frame");
a_out_at_rise: assert property ($rose(sclk) && d_io1_oe |-> $stable(d_io1_o))
    else $error("output moved at sampling edge");
a_sclk_idle: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("serial clock runs outside frame");
a_sclk_high: assert property ($rose(sclk) |-> sclk[*3])
    else $error("serial clock high too short");
a_sleep_excl: assert property (deep_sleep |-> !standby && !d_io0_oe)
    else $error("standby during deep sleep");
// wake delay is 10 cycles in the bench, so standby must wait
a_wake_delay: assert property ($fell(deep_sleep) |-> !standby[*5] ##[1:15] standby)
    else $error("wake delay wrong");
a_wake_gap: assert property ($fell(deep_sleep) |-> cs_n[*8])
    else $error("select low during wake delay");
endmodule // fsc_link_properties
`default_nettype wire

// [verification/testbench.sv]
// testbench: host and device ends joined by the link
// assumes short sleep and wake counts of 10 cycles
`include "fsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
typedef struct {fsc_pkg::fsc_hcmd_t op; logic [1:0] sel; logic [8:0] off; logic [7:0] len;} fsc_row_t;
logic core_clk = 0, rst = 1, cmd_valid = 0, wip = 0, mem_wr_en = 0;
logic cmd_ready, rsp_valid, done, deep_sleep, standby;
fsc_pkg::fsc_hcmd_t cmd_op = fsc_pkg::HC_SECREG;
logic [1:0] cmd_sel = 0;
logic [8:0] cmd_offset = 0;
logic [7:0] cmd_len = 0, rsp_data, mem_wr_data = 0;
logic [10:0] mem_wr_idx = 0;
logic [7:0] got[$];
int errors = 0, num_checks = 0;
fsc_row_t rows[8];
always #5 core_clk = ~core_clk;
fsc_link_if link ();
fsc_device #(.SLEEP_CYC(10), .WAKE_CYC(10)) i_fsc_device (.core_clk(core_clk), .rst(rst), .link(link),
    .wip(wip), .mem_wr_en(mem_wr_en), .mem_wr_idx(mem_wr_idx), .mem_wr_data(mem_wr_data),
    .deep_sleep(deep_sleep), .standby(standby));
fsc_host #(.WAKE_CYC(10)) i_fsc_host (.core_clk(core_clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_offset(cmd_offset), .cmd_len(cmd_len),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .done(done));
fsc_link_properties i_fsc_link_properties (.core_clk(core_clk), .rst(rst), .cs_n(link.cs_n),
    .sclk(link.sclk), .d_io0_oe(link.d_io0_oe), .d_io1_oe(link.d_io1_oe), .d_io1_o(link.d_io1_o),
    .deep_sleep(deep_sleep), .standby(standby));
////////////////////////////////////////////////////////////
task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] a);
    num_checks++;
    if (a !== e)
    begin
        errors++;
        $display("MISMATCH %s exp %h got %h", nm, e, a);
    end
endtask
task automatic chk1(input string nm, input logic e, input logic a);
    num_checks++;
    if (a !== e)
    begin
        errors++;
        $display("MISMATCH %s exp %b got %b", nm, e, a);
    end
endtask
// secreg pattern, so that a wrong register or offset shows
function automatic logic [7:0] expb(input fsc_row_t r, input int k);
    logic [10:0] ix;
    ix = 11'((r.sel - 1) * 512) + 11'(9'(r.off + k));
    if (r.op == fsc_pkg::HC_SECREG)
        return ix[7:0] ^ {5'h0, ix[10:8]};
    if (r.op == fsc_pkg::HC_SIG)
        return `FSC_SIGNATURE;
    return ((k + r.off[0]) % 2 == 0) ? `FSC_MAKER_ID : `FSC_DEVICE_ID;
endfunction
task automatic run(input fsc_row_t r);
    int n;
    n = 0;
    got = {};
    @(negedge core_clk);
    cmd_op = r.op;
    cmd_sel = r.sel;
    cmd_offset = r.off;
    cmd_len = r.len;
    cmd_valid = 1;
    @(negedge core_clk);
    cmd_valid = 0;
    do
    begin
        @(negedge core_clk);
        if (rsp_valid === 1'b1)
            got.push_back(rsp_data);
        n++;
    end while (done !== 1'b1 && n < 5000);
    if (n >= 5000)
    begin
        errors++;
        test_done();
    end
endtask
task automatic sleep_wait();
    int n;
    n = 0;
    run('{fsc_pkg::HC_SLEEP, 0, 0, 1});
    while (deep_sleep !== 1'b1 && n < 100)
    begin
        @(negedge core_clk);
        n++;
    end
    chk1("deep_sleep", 1'b1, deep_sleep);
endtask
////////////////////////////////////////////////////////////
initial
begin
    rows = '{'{fsc_pkg::HC_SECREG, 1, 0, 2}, '{fsc_pkg::HC_SECREG, 2, 9'h1FE, 4},
        '{fsc_pkg::HC_SECREG, 3, 9'h100, 1}, '{fsc_pkg::HC_ID, 0, 0, 3}, '{fsc_pkg::HC_ID, 0, 1, 3},
        '{fsc_pkg::HC_ID2, 0, 0, 4}, '{fsc_pkg::HC_ID2, 0, 1, 2}, '{fsc_pkg::HC_SIG, 0, 0, 3}};
    repeat (8) @(negedge core_clk);
    rst = 0;
    chk1("standby", 1'b1, standby);
    chk1("ready", 1'b1, cmd_ready);
    for (int i = 0; i < 1536; i++)
    begin
        @(negedge core_clk);
        {mem_wr_en, mem_wr_idx, mem_wr_data} = {1'b1, 11'(i), 8'(i) ^ 8'(i >> 8)};
    end
    @(negedge core_clk);
    mem_wr_en = 0;
    foreach (rows[r])
    begin
        run(rows[r]);
        chk8("count", rows[r].len, 8'(got.size()));
        foreach (got[k]) chk8("byte", expb(rows[r], k), got[k]);
        $display("row %0d done", r);
    end
    sleep_wait();
    run('{fsc_pkg::HC_ID, 0, 0, 1});
    chk8("refused", 8'hFF, got[0]);
    wip = 1;
    run('{fsc_pkg::HC_WAKE, 0, 0, 1});
    wip = 0;
    chk1("busy wake", 1'b1, deep_sleep);
    run('{fsc_pkg::HC_WAKE, 0, 0, 1});
    repeat (12) @(negedge core_clk);
    chk1("woken", 1'b1, standby);
    $display("sleep and wake done");
    sleep_wait();
    run('{fsc_pkg::HC_SIG, 0, 0, 1});
    chk8("signature", `FSC_SIGNATURE, got[0]);
    repeat (12) @(negedge core_clk);
    chk1("sig wake", 1'b1, standby);
    sleep_wait();
    rst = 1;
    repeat (2) @(negedge core_clk);
    rst = 0;
    chk1("reset standby", 1'b1, standby);
    chk1("reset sleep", 1'b0, deep_sleep);
    $display("reset from sleep done");
    test_done();
end
endmodule // testbench
`default_nettype wire
